// ---- src/regulator_pkg.sv ----
`default_nettype none
package regulator_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] IDX_LEVEL_LOW = 8'h00;
  localparam logic [7:0] IDX_LEVEL_HIGH = 8'h01;
  localparam logic [7:0] IDX_CONFIG = 8'h02;
  localparam logic [7:0] IDX_VENDOR = 8'h03;
  localparam logic [7:0] IDX_REVISION = 8'h04;
  localparam logic [7:0] IDX_STATE = 8'h05;
  localparam int REG_COUNT = 6;
  localparam logic [7:0] RST_LEVEL_LOW = 8'hAD;
  localparam logic [7:0] RST_LEVEL_HIGH = 8'hFC;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  // reserved config bits 3:0 always read zero
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'hF0;
  localparam int REGULATING_BIT = 7;
  // arbitrary identity values
  localparam logic [7:0] VENDOR_CHIP_DEFAULT = 8'h5A;
  localparam logic [3:0] DIE_REVISION_DEFAULT = 4'h3;

  // ************************************************************
  // serial target address
  // ************************************************************
  localparam logic [7:0] TARGET_ADDR = 8'hC0;
  localparam logic [7:0] VARIANT_ADDR_BIT = 8'h04;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 10;
  localparam int OVP_FILTER_NS = 1000;
  localparam int OVP_FILTER_CYC = (OVP_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int SOFT_START_US = 200;
  localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
  localparam int RESTART_US = 1700;
  localparam int LIMIT_RUN = 16;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic sw_enable;
    logic forced_pwm;
    logic [5:0] voltage_code;
  } level_setting_type;

  typedef struct packed {
    logic discharge;
    logic [2:0] ramp_rate;
    logic [3:0] reserved;
  } config_type;

  typedef struct packed {
    logic enable;
    logic select;
    logic undervoltage_lockout;
    logic input_overvoltage_trip;
    logic over_temp;
    logic current_limit;
    logic cycle_clock;
    logic pwm_request;
  } pin_sample_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic enable;
  } bus_line_type;

  typedef enum logic [1:0] {R_OFF, R_SOFT, R_RUN, R_FAULT} run_state_type;
  typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK, L_TX, L_TXACK} link_state_type;
  typedef enum logic [1:0] {K_ADDR, K_INDEX, K_DATA} byte_kind_type;
endpackage : regulator_pkg
`default_nettype wire

// ---- src/bit_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk) begin
    meta <= i_d;
    o_q <= meta;
  end
endmodule : bit_sync
`default_nettype wire

// ---- src/regulator_i2c_control_and_status.sv ----
// How it works
// - over-voltage, filtered, stops switching
// - power good low whenever regulator disabled
// - power good low through soft-start
// - level changes by bus keep power good
// - current limit ends high side for cycle
// - sixteen limited cycles: off, wait, restart
// - over-temperature stops switching until cleared
// - state register reads regulating in bit 7
// - scl input only, sda open-drain pull-down
// - bytes shift most significant bit first
// - answer to address C0, variant C4
// - sample sda on rising scl
// - start and stop frame each transaction
// - high-speed master code never acknowledged
// - repeated start keeps high-speed until stop
// - acknowledge by pulling sda low
// - select pin picks active level register
// - config register holds discharge and slew
// - vendor identity read-only, writes ignored
// - revision register upper nibble zero
// - enable low: bus ignored; reset restores defaults
// - level register: enable, pwm, voltage code
// - config fields, reserved bits read zero
`timescale 1ns/100ps
`default_nettype none
module regulator_i2c_control_and_status
  import regulator_pkg::*;
#(
  parameter int RESTART_US_P = RESTART_US,
  parameter bit ADDR_VARIANT = 1'b0,
  parameter logic [7:0] VENDOR_CHIP_ID = VENDOR_CHIP_DEFAULT,
  parameter logic [3:0] DIE_REVISION = DIE_REVISION_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_enable_pin,
  input wire logic i_voltage_select_pin,
  input wire logic i_undervoltage_lockout,
  input wire logic i_input_overvoltage_trip,
  input wire logic i_over_temp,
  input wire logic i_current_limit,
  input wire logic i_cycle_clock,
  input wire logic i_pwm_request,
  output logic o_switch_enable,
  output logic o_high_side_on,
  output logic o_discharge,
  output logic o_forced_pwm,
  output logic [5:0] o_voltage_code,
  output logic [2:0] o_ramp_rate,
  output logic o_power_good_out,
  output logic o_power_good_oe
);
  localparam int RESTART_CYC = RESTART_US_P * CLK_MHZ;
  localparam int TW = $clog2(RESTART_CYC + SOFT_START_CYC + 1);
  localparam int OW = $clog2(OVP_FILTER_CYC + 1);
  localparam logic [TW-1:0] SOFT_LAST = TW'(SOFT_START_CYC - 1);
  localparam logic [TW-1:0] RESTART_LAST = TW'(RESTART_CYC - 1);
  localparam logic [OW-1:0] OVP_LAST = OW'(OVP_FILTER_CYC - 1);
  localparam logic [4:0] LIMIT_LAST = 5'(LIMIT_RUN - 1);
  localparam logic [7:0] OWN_ADDR = TARGET_ADDR | (ADDR_VARIANT ? VARIANT_ADDR_BIT : 8'h00);

  // ************************************************************
  // core domain declarations
  // ************************************************************
  pin_sample_type pins_raw;
  pin_sample_type pins;
  level_setting_type level_low;
  level_setting_type level_high;
  level_setting_type active;
  config_type cfg;
  run_state_type run_state;
  logic [TW-1:0] timer;
  logic [OW-1:0] ovp_cnt;
  logic ovp_filt;
  logic gated;
  logic switching;
  logic enable_req;
  logic regulating;
  logic cyc_q;
  logic cycle_edge;
  logic limited;
  logic [4:0] run_count;
  logic limit_trip;
  logic [1:0] tgl_s;
  logic wr_seen;
  logic wr_fire;
  logic [7:0] snap [REG_COUNT];
  logic snap_tgl;

  // ************************************************************
  // link domain declarations
  // ************************************************************
  logic link_rst;
  bus_line_type line_raw;
  bus_line_type line;
  bus_line_type line_q;
  logic snap_s;
  logic ack_tgl;
  logic [7:0] mirror [REG_COUNT];
  link_state_type lstate;
  byte_kind_type kind;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] idx;
  logic rd;
  logic more;
  logic [7:0] tx_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic tx_load;
  logic wr_tgl;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  assign pins_raw = '{
    enable: i_enable_pin,
    select: i_voltage_select_pin,
    undervoltage_lockout: i_undervoltage_lockout,
    input_overvoltage_trip: i_input_overvoltage_trip,
    over_temp: i_over_temp,
    current_limit: i_current_limit,
    cycle_clock: i_cycle_clock,
    pwm_request: i_pwm_request
  };

  bit_sync #(.WIDTH($bits(pin_sample_type))) u_pin_sync (
    .i_clk(i_clk),
    .i_d(pins_raw),
    .o_q(pins)
  );

  bit_sync #(.WIDTH(2)) u_tgl_sync (
    .i_clk(i_clk),
    .i_d({wr_tgl, ack_tgl}),
    .o_q(tgl_s)
  );

  assign line_raw = '{scl: i_scl, sda: i_sda, enable: i_enable_pin};

  bit_sync #(.WIDTH($bits(bus_line_type))) u_line_sync (
    .i_clk(i_link_clk),
    .i_d(line_raw),
    .o_q(line)
  );

  bit_sync #(.WIDTH(2)) u_link_ctl_sync (
    .i_clk(i_link_clk),
    .i_d({i_srst, snap_tgl}),
    .o_q({link_rst, snap_s})
  );

  // ************************************************************
  // register file
  // ************************************************************
  assign active = pins.select ? level_high : level_low;
  assign wr_fire = tgl_s[1] ^ wr_seen;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      level_low <= RST_LEVEL_LOW;
      level_high <= RST_LEVEL_HIGH;
      cfg <= RST_CONFIG;
      wr_seen <= 1'b0;
    end else begin
      wr_seen <= tgl_s[1];
      if (wr_fire) begin
        // held words are stable for a whole byte after the toggle
        unique case (wr_idx)
          IDX_LEVEL_LOW: level_low <= wr_data;
          IDX_LEVEL_HIGH: level_high <= wr_data;
          IDX_CONFIG: cfg <= wr_data & CONFIG_WRITE_MASK;
          default: ;
        endcase
      end
    end
  end

  // continuous mirror loop: a read sees values up to about a microsecond old
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      snap_tgl <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++) begin
        snap[i] <= 8'h00;
      end
    end else if (tgl_s[0] == snap_tgl) begin
      snap[IDX_LEVEL_LOW[2:0]] <= level_low;
      snap[IDX_LEVEL_HIGH[2:0]] <= level_high;
      snap[IDX_CONFIG[2:0]] <= cfg;
      snap[IDX_VENDOR[2:0]] <= VENDOR_CHIP_ID;
      snap[IDX_REVISION[2:0]] <= {4'h0, DIE_REVISION};
      snap[IDX_STATE[2:0]] <= 8'(regulating) << REGULATING_BIT;
      snap_tgl <= ~snap_tgl;
    end
  end

  // ************************************************************
  // protection and run control
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst || !pins.input_overvoltage_trip) begin
      ovp_cnt <= '0;
      ovp_filt <= 1'b0;
    end else if (ovp_cnt == OVP_LAST) begin
      ovp_filt <= 1'b1;
    end else begin
      ovp_cnt <= ovp_cnt + 1'b1;
    end
  end

  assign gated = ovp_filt | pins.over_temp;
  assign enable_req = pins.enable & ~pins.undervoltage_lockout & active.sw_enable;
  assign switching = (run_state == R_SOFT || run_state == R_RUN) && !gated;
  assign regulating = (run_state == R_RUN) && !gated;
  assign cycle_edge = pins.cycle_clock & ~cyc_q;
  assign limit_trip = cycle_edge & limited & (run_count == LIMIT_LAST);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cyc_q <= 1'b0;
      limited <= 1'b0;
      run_count <= '0;
    end else begin
      cyc_q <= pins.cycle_clock;
      // a limit arriving on the boundary belongs to the new cycle
      if (cycle_edge) begin
        limited <= pins.current_limit;
      end else if (pins.current_limit) begin
        limited <= 1'b1;
      end
      if (!switching) begin
        run_count <= '0;
      end else if (cycle_edge) begin
        run_count <= limited ? run_count + 1'b1 : 5'h00;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      run_state <= R_OFF;
      timer <= '0;
    end else if (!enable_req) begin
      run_state <= R_OFF;
      timer <= '0;
    end else begin
      unique case (run_state)
        R_OFF: begin
          run_state <= R_SOFT;
          timer <= '0;
        end
        R_SOFT: begin
          timer <= timer + 1'b1;
          if (limit_trip) begin
            run_state <= R_FAULT;
            timer <= '0;
          end else if (timer == SOFT_LAST) begin
            run_state <= R_RUN;
          end
        end
        R_RUN: begin
          if (limit_trip) begin
            run_state <= R_FAULT;
            timer <= '0;
          end
        end
        R_FAULT: begin
          if (timer == RESTART_LAST) begin
            run_state <= R_SOFT;
            timer <= '0;
          end else begin
            timer <= timer + 1'b1;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // core outputs
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_switch_enable <= 1'b0;
      o_high_side_on <= 1'b0;
      o_discharge <= 1'b0;
      o_forced_pwm <= 1'b0;
      o_voltage_code <= 6'h00;
      o_ramp_rate <= 3'h0;
      o_power_good_out <= 1'b0;
      o_power_good_oe <= 1'b1;
    end else begin
      o_switch_enable <= switching;
      o_high_side_on <= switching & pins.pwm_request & ~limited & ~pins.current_limit;
      o_discharge <= cfg.discharge & ~(pins.enable & active.sw_enable);
      o_forced_pwm <= active.forced_pwm;
      o_voltage_code <= active.voltage_code;
      o_ramp_rate <= cfg.ramp_rate;
      o_power_good_out <= 1'b0;
      // level codes do not enter this term, so retargeting keeps it
      o_power_good_oe <= ~(regulating & enable_req);
    end
  end

  // ************************************************************
  // link side: mirror and line events
  // ************************************************************
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      ack_tgl <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++) begin
        mirror[i] <= 8'h00;
      end
    end else if (snap_s != ack_tgl) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mirror[i] <= snap[i];
      end
      ack_tgl <= snap_s;
    end
  end

  always_ff @(posedge i_link_clk) begin
    line_q <= line;
    o_sda_out <= 1'b0;
  end

  assign scl_rise = line.scl & ~line_q.scl;
  assign scl_fall = ~line.scl & line_q.scl;
  assign start_seen = line_q.sda & ~line.sda & line.scl & line_q.scl;
  assign stop_seen = ~line_q.sda & line.sda & line.scl & line_q.scl;
  assign tx_byte = (idx < 8'(REG_COUNT)) ? mirror[idx[2:0]] : 8'h00;
  assign tx_load = scl_fall && ((lstate == L_ACK && rd) || (lstate == L_TXACK && more));

  // ************************************************************
  // link side: serial target
  // ************************************************************
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      lstate <= L_IDLE;
      kind <= K_ADDR;
      cnt <= 4'h0;
      shreg <= 8'h00;
      idx <= 8'h00;
      rd <= 1'b0;
      more <= 1'b0;
      o_sda_oe <= 1'b0;
      wr_tgl <= 1'b0;
      wr_idx <= 8'h00;
      wr_data <= 8'h00;
    end else if (!line.enable) begin
      lstate <= L_IDLE;
      o_sda_oe <= 1'b0;
    end else if (start_seen) begin
      // repeated starts land here too, high-speed framing included
      lstate <= L_RX;
      kind <= K_ADDR;
      cnt <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (stop_seen) begin
      lstate <= L_IDLE;
      o_sda_oe <= 1'b0;
    end else if (tx_load) begin
      o_sda_oe <= ~tx_byte[7];
      shreg <= {tx_byte[6:0], 1'b0};
      cnt <= 4'h1;
      idx <= idx + 1'b1;
      lstate <= L_TX;
    end else begin
      unique case (lstate)
        L_IDLE: ;
        L_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], line.sda};
            cnt <= cnt + 1'b1;
          end else if (scl_fall && cnt == BITS_PER_BYTE) begin
            unique case (kind)
              K_ADDR: begin
                // master code and foreign addresses get no pull-down
                if (shreg[7:1] == OWN_ADDR[7:1]) begin
                  rd <= shreg[0];
                  o_sda_oe <= 1'b1;
                  lstate <= L_ACK;
                end else begin
                  lstate <= L_IDLE;
                end
              end
              K_INDEX: begin
                idx <= shreg;
                o_sda_oe <= 1'b1;
                lstate <= L_ACK;
              end
              K_DATA: begin
                wr_idx <= idx;
                wr_data <= shreg;
                wr_tgl <= ~wr_tgl;
                idx <= idx + 1'b1;
                o_sda_oe <= 1'b1;
                lstate <= L_ACK;
              end
            endcase
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            o_sda_oe <= 1'b0;
            kind <= (kind == K_ADDR) ? K_INDEX : K_DATA;
            cnt <= 4'h0;
            lstate <= L_RX;
          end
        end
        L_TX: begin
          if (scl_fall) begin
            if (cnt == BITS_PER_BYTE) begin
              o_sda_oe <= 1'b0;
              more <= 1'b0;
              lstate <= L_TXACK;
            end else begin
              o_sda_oe <= ~shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              cnt <= cnt + 1'b1;
            end
          end
        end
        L_TXACK: begin
          if (scl_rise) begin
            more <= ~line.sda;
          end else if (scl_fall) begin
            lstate <= L_IDLE;
          end
        end
      endcase
    end
  end
endmodule : regulator_i2c_control_and_status
`default_nettype wire

// ---- bench/regulator_i2c_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module regulator_i2c_properties (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_enable_pin,
  input wire logic i_undervoltage_lockout,
  input wire logic i_input_overvoltage_trip,
  input wire logic i_over_temp,
  input wire logic i_current_limit,
  input wire logic i_cycle_clock,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_switch_enable,
  input wire logic o_high_side_on,
  input wire logic o_power_good_oe
);
  // ********
  // helpers
  // ********
  // saturating run of the raw trip input
  logic [4:0] ovp_run;
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_input_overvoltage_trip) begin
      ovp_run <= 5'h00;
    end else if (ovp_run != 5'h1F) begin
      ovp_run <= ovp_run + 5'h01;
    end
  end
  // link logic leaves reset up to three link cycles after the core
  logic [2:0] lrst;
  always_ff @(posedge i_link_clk) begin
    lrst <= {lrst[1:0], i_srst};
  end
  // long enough that no cycle edge can clear the seen flag
  sequence s_limit_held;
    (i_current_limit && !i_cycle_clock)[*8];
  endsequence
  sequence s_off_held;
    (!i_enable_pin || i_undervoltage_lockout)[*4];
  endsequence
  // ********
  // properties
  // ********
  a_pg_disabled: assert property (@(posedge i_clk) disable iff (i_srst)
    s_off_held |-> o_power_good_oe) else $error("power good while disabled");
  a_sw_disabled: assert property (@(posedge i_clk) disable iff (i_srst)
    (!i_enable_pin)[*6] |-> !o_switch_enable) else $error("switching while disabled");
  a_hot_gates: assert property (@(posedge i_clk) disable iff (i_srst)
    i_over_temp[*4] |-> !o_switch_enable) else $error("switching while hot");
  a_ovp_gates: assert property (@(posedge i_clk) disable iff (i_srst)
    ovp_run >= 5'h10 |-> !o_switch_enable) else $error("switching during trip");
  a_limit_cuts: assert property (@(posedge i_clk) disable iff (i_srst)
    s_limit_held |-> !o_high_side_on) else $error("high side on at limit");
  a_pg_needs_switch: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_power_good_oe |-> o_switch_enable) else $error("power good while stopped");
  a_sda_pull_only: assert property (@(posedge i_link_clk) disable iff (i_srst || |lrst)
    o_sda_out == 1'b0) else $error("data pin driven high");
  a_oe_scl_low: assert property (@(posedge i_link_clk) disable iff (i_srst || |lrst)
    $changed(o_sda_oe) |-> !i_scl) else $error("data changed while clock high");
  a_quiet_disabled: assert property (@(posedge i_link_clk) disable iff (i_srst || |lrst)
    (!i_enable_pin)[*8] |-> !o_sda_oe) else $error("bus answered while disabled");
endmodule : regulator_i2c_properties
`default_nettype wire

// ---- bench/i2c_controller_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module i2c_controller_model
  import regulator_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  // ********
  // bus phases
  // ********
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  // six core cycles keep each level above four link cycles
  task automatic phase;
    repeat (6) @(posedge i_clk);
  endtask : phase
  task automatic start_cond;
    phase();
    o_sda_pull <= 1'b0;
    phase();
    o_scl <= 1'b1;
    phase();
    o_sda_pull <= 1'b1;
    phase();
    o_scl <= 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    phase();
    o_sda_pull <= 1'b1;
    phase();
    o_scl <= 1'b1;
    phase();
    o_sda_pull <= 1'b0;
    phase();
  endtask : stop_cond
  task automatic clock_bit(input logic pull, output logic seen);
    phase();
    o_sda_pull <= pull;
    phase();
    o_scl <= 1'b1;
    phase();
    seen = i_sda;
    o_scl <= 1'b0;
  endtask : clock_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(~b[i], s);
    end
    clock_bit(1'b0, s);
    ack = ~s;
  endtask : send_byte
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b0, b[i]);
    end
    clock_bit(~nack, s);
  endtask : recv_byte
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start_cond();
    send_byte(TARGET_ADDR, a0);
    send_byte(idx, a1);
    send_byte(d, a2);
    stop_cond();
    ack = a0 & a1 & a2;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] d);
    logic a;
    start_cond();
    send_byte(TARGET_ADDR, a);
    send_byte(idx, a);
    start_cond();
    send_byte(TARGET_ADDR | 8'h01, a);
    recv_byte(1'b1, d);
    stop_cond();
  endtask : read_reg
endmodule : i2c_controller_model
`default_nettype wire

// ---- bench/test_regulator_i2c_control_and_status.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_regulator_i2c_control_and_status;
  import regulator_pkg::*;
  // ********
  // setup
  // ********
  localparam logic [7:0] VENDOR_TB = 8'h3C; // arbitrary value
  localparam logic [3:0] REV_TB = 4'h6; // arbitrary value
  // short restart wait keeps the run brief
  localparam int RESTART_TB = 5;
  localparam int OFF_CYC = RESTART_TB * CLK_MHZ;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wr;
    logic [7:0] exp;
  } row_type;
  row_type rows [6] = '{
    '{IDX_LEVEL_LOW, 8'hD5, 8'hD5},
    '{IDX_LEVEL_HIGH, 8'hEA, 8'hEA},
    '{IDX_CONFIG, 8'hFF, 8'hF0},
    '{IDX_VENDOR, 8'hC3, VENDOR_TB},
    '{IDX_REVISION, 8'hFF, {4'h0, REV_TB}},
    '{IDX_STATE, 8'h00, 8'h80}};
  logic [7:0] dflt [3] = '{RST_LEVEL_LOW, RST_LEVEL_HIGH, RST_CONFIG};
  logic [7:0] bad [2] = '{8'hC4, 8'h0F};
  logic clk = 1'b0, link_clk = 1'b0, srst = 1'b1, en = 1'b1, sel = 1'b0, undervoltage_lockout = 1'b0;
  logic input_overvoltage_trip = 1'b0, temp = 1'b0, lim = 1'b0, cyc = 1'b0, pwm = 1'b1, watch_pg = 1'b0;
  logic [3:0] cyc_cnt = 4'h0;
  logic scl, sda_pull, sda_oe, sw_en, hs_on, dis, fpwm, pg_oe, pg_out, ack;
  logic [5:0] vcode;
  logic [2:0] ramp;
  logic [7:0] rd;
  int fails = 0, n_tests = 0, pg_drop = 0, n = 0;
  // pull-up wins unless someone pulls low
  wire logic sda = ~(sda_pull | (sda_oe === 1'b1));
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #37;
    forever #62.5 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 4'h1;
    cyc <= cyc_cnt[3];
    if (watch_pg && pg_oe !== 1'b0) pg_drop++;
  end
  regulator_i2c_control_and_status #(.RESTART_US_P(RESTART_TB), .VENDOR_CHIP_ID(VENDOR_TB),
    .DIE_REVISION(REV_TB)) regulator_i2c_control_and_status_i (.i_clk(clk), .i_srst(srst),
    .i_link_clk(link_clk), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_enable_pin(en), .i_voltage_select_pin(sel), .i_undervoltage_lockout(undervoltage_lockout),
    .i_input_overvoltage_trip(input_overvoltage_trip), .i_over_temp(temp), .i_current_limit(lim),
    .i_cycle_clock(cyc), .i_pwm_request(pwm), .o_switch_enable(sw_en), .o_high_side_on(hs_on),
    .o_discharge(dis), .o_forced_pwm(fpwm), .o_voltage_code(vcode), .o_ramp_rate(ramp),
    .o_power_good_out(pg_out), .o_power_good_oe(pg_oe));
  i2c_controller_model ctl_i (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(sda_pull));
  // ********
  // checks
  // ********
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask : chk_bit
  task automatic wait_sw(input logic v, input int lim_cyc);
    n = 0;
    while (sw_en !== v && n < lim_cyc) begin
      @(negedge clk);
      n++;
    end
    chk_bit(sw_en, v, "switch enable");
  endtask : wait_sw
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    // link side still sees three reset edges in four core cycles
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (1900) @(negedge clk);
    chk_bit(pg_oe, 1'b1, "pg in soft-start");
    chk_bit(sw_en, 1'b1, "soft-start switching");
    repeat (200) @(negedge clk);
    chk_bit(pg_oe, 1'b0, "pg after soft-start");
    chk_bit(hs_on, 1'b1, "high side on");
    $display("soft-start done");
    watch_pg = 1'b1;
    for (int r = 0; r < 6; r++) begin
      ctl_i.write_reg(rows[r].idx, rows[r].wr, ack);
      chk_bit(ack, 1'b1, "write ack");
      ctl_i.read_reg(rows[r].idx, rd);
      chk_byte(rd, rows[r].exp, "register read");
    end
    watch_pg = 1'b0;
    @(negedge clk);
    chk_bit(pg_drop == 0, 1'b1, "pg kept over writes");
    chk_byte({fpwm, 1'b0, vcode}, 8'h95, "low setting");
    chk_byte({5'h00, ramp}, 8'h07, "ramp rate");
    @(posedge clk) sel <= 1'b1;
    repeat (5) @(negedge clk);
    chk_byte({2'h0, vcode}, 8'h2A, "high setting");
    $display("registers done");
    @(posedge clk) input_overvoltage_trip <= 1'b1;
    repeat (5) @(posedge clk);
    input_overvoltage_trip <= 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(sw_en, 1'b1, "spike filtered");
    @(posedge clk) input_overvoltage_trip <= 1'b1;
    repeat (20) @(negedge clk);
    chk_bit(sw_en, 1'b0, "trip stops switching");
    chk_bit(pg_oe, 1'b1, "pg low on trip");
    chk_bit(pg_out, 1'b0, "pg pin level");
    @(posedge clk) input_overvoltage_trip <= 1'b0;
    wait_sw(1'b1, 20);
    @(posedge clk) temp <= 1'b1;
    repeat (6) @(negedge clk);
    chk_bit(sw_en, 1'b0, "hot stops switching");
    ctl_i.read_reg(IDX_STATE, rd);
    chk_byte(rd, 8'h00, "state while hot");
    @(posedge clk) temp <= 1'b0;
    wait_sw(1'b1, 10);
    $display("gating done");
    @(posedge clk) lim <= 1'b1;
    repeat (12) @(negedge clk);
    chk_bit(hs_on, 1'b0, "limit cuts high side");
    wait_sw(1'b0, 300);
    @(posedge clk) lim <= 1'b0;
    wait_sw(1'b1, OFF_CYC + 20);
    chk_bit(n >= OFF_CYC - 5 && n <= OFF_CYC + 5, 1'b1, "restart wait");
    chk_bit(pg_oe, 1'b1, "pg in restart");
    $display("fault done");
    foreach (bad[i]) begin
      ctl_i.start_cond();
      ctl_i.send_byte(bad[i], ack);
      chk_bit(ack, 1'b0, "foreign address");
      ctl_i.stop_cond();
    end
    ctl_i.start_cond();
    ctl_i.send_byte(8'h08, ack);
    chk_bit(ack, 1'b0, "master code");
    ctl_i.start_cond();
    ctl_i.send_byte(TARGET_ADDR, ack);
    chk_bit(ack, 1'b1, "address after code");
    ctl_i.stop_cond();
    $display("addressing done");
    @(posedge clk) en <= 1'b0;
    repeat (8) @(negedge clk);
    chk_bit(pg_oe, 1'b1, "pg low when off");
    chk_bit(dis, 1'b1, "discharge when off");
    ctl_i.write_reg(IDX_LEVEL_LOW, 8'h00, ack);
    chk_bit(ack, 1'b0, "quiet when off");
    @(posedge clk) en <= 1'b1;
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (30) @(negedge clk);
    foreach (dflt[i]) begin
      ctl_i.read_reg(8'(i), rd);
      chk_byte(rd, dflt[i], "reset default");
    end
    $display("reset done");
    complete_run();
  end
endmodule : test_regulator_i2c_control_and_status
bind regulator_i2c_control_and_status regulator_i2c_properties props_i (.i_clk, .i_srst,
  .i_link_clk, .i_scl, .i_enable_pin, .i_undervoltage_lockout, .i_input_overvoltage_trip,
  .i_over_temp, .i_current_limit, .i_cycle_clock, .o_sda_out, .o_sda_oe, .o_switch_enable,
  .o_high_side_on, .o_power_good_oe);
`default_nettype wire
